// [hdl/pmsc_pkg.sv]
// package: register map, field positions and reset values of the unit control
package pmsc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int FRAME_W = 1 + ADDR_W + DATA_W;
  localparam logic [4:0] ADDR_FORCE_LEVEL_DAC = 5'h0B;
  localparam logic [4:0] ADDR_UNIT_ENABLE = 5'h0C;
  localparam logic [4:0] ADDR_CHANNEL_STATE = 5'h0D;
  localparam logic [4:0] ADDR_UNIT_STATE = 5'h0E;
  localparam logic [4:0] ADDR_MEASURE_ENABLE = 5'h0F;
  localparam logic [4:0] ADDR_DIFF_COMP_ENABLE = 5'h10;
  localparam logic [4:0] ADDR_OVD_MASK_CH0 = 5'h11;
  localparam logic [4:0] ADDR_OVD_MASK_CH1 = 5'h12;
  localparam logic [15:0] RST_FORCE_LEVEL_DAC = 16'h0000;
  localparam logic [15:0] RST_UNIT_ENABLE = 16'h0000;
  localparam logic [15:0] RST_CHANNEL_STATE = 16'h0000;
  localparam logic [15:0] RST_UNIT_STATE = 16'h0000;
  localparam logic [15:0] RST_MEASURE_ENABLE = 16'h0000;
  localparam logic [15:0] RST_DIFF_COMP_ENABLE = 16'h0000;
  localparam logic [15:0] RST_OVD_MASK = 16'h0000;
  // unit_enable fields
  localparam int EN_TERM_LEVEL_BIT = 0;
  localparam int EN_PIN_ELEC_OFF_BIT = 1;
  localparam int EN_PARAM_UNIT_BIT = 2;
  // channel state fields
  localparam int CH_HV_OUT_BIT = 0;
  localparam int CH_LOAD_BIT = 1;
  localparam int CH_TERM_DRIVE_BIT = 2;
  // unit_state fields
  localparam int ST_INSEL_HI = 9;
  localparam int ST_INSEL_LO = 8;
  localparam int ST_EXT_SENSE_BIT = 7;
  localparam int ST_CLAMP_BIT = 6;
  localparam int ST_MEAS_I_BIT = 4;
  localparam int ST_FORCE_I_BIT = 3;
  localparam int ST_RANGE_HI = 2;
  localparam int ST_RANGE_LO = 0;
  localparam int MEAS_EN_BIT = 0;
  // input selection codes
  localparam logic [1:0] INSEL_GROUND = 2'h0;
  localparam logic [1:0] INSEL_OFFSET = 2'h1;
  // serial framing: read flag, 5-bit address, 16-bit data, msb first
  localparam int RD_BIT = FRAME_W - 1;
  localparam logic [4:0] NUM_RANGES = 5'h05;
endpackage : pmsc_pkg

// [hdl/pmsc_reg16.sv]
// file: one 16-bit control register with load strobe
`timescale 1ns/10ps
`default_nettype none
module pmsc_reg16
  import pmsc_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000
)
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic load_i,
  input wire logic [15:0] data_i,
  output logic [15:0] q_o
);
  logic [15:0] q_r;
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      q_r <= RST_VAL;
    else if (load_i)
      q_r <= data_i;
  end
  assign q_o = q_r;
endmodule : pmsc_reg16
`default_nettype wire

// [hdl/pmsc_ctrl.sv]
// file: serial-programmed mode control registers of the parametric unit
//
// Functional notes
// - enable register at zero: unit off, no termination level, pins on.
// - channel state at zero: high-voltage output, load, termination all off.
// - unit state zero: ground input, internal sense, no clamps, FV, range E.
// - measure enable zero keeps shared measure output high impedance.
// - comparator enable zero keeps window mode, not differential.
// - overvoltage mask zero disables that channel's alarm functions.
// - then enable bit set; unit runs forcing voltage.
// - five-bit address decode: DAC 0x0B, enable 0x0C, state 0x0E.
// - enable bit low opens all range switches and powers unit down.
`timescale 1ns/10ps
`default_nettype none
module pmsc_ctrl
  import pmsc_pkg::*;
(
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic SCLK_I,
  input wire logic CS_N_I,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  output logic [15:0] FORCE_LEVEL_DAC_O,
  output logic PARAM_UNIT_ON_O,
  output logic [4:0] RANGE_SWITCH_O,
  output logic FORCE_CURRENT_O,
  output logic MEASURE_CURRENT_O,
  output logic [1:0] INPUT_SELECT_O,
  output logic EXT_SENSE_O,
  output logic CLAMP_ON_O,
  output logic TERM_LEVEL_FORCE_O,
  output logic PIN_ELECTRONICS_ON_O,
  output logic HIGH_VOLTAGE_OUTPUT_O,
  output logic ACTIVE_LOAD_O,
  output logic TERMINATION_DRIVE_O,
  output logic SHARED_MEASURE_OE_O,
  output logic DIFF_COMPARE_O,
  output logic [15:0] OVD_ALARM_MASK0_O,
  output logic [15:0] OVD_ALARM_MASK1_O
);
  localparam int NREG = 8;
  localparam logic [4:0] REG_ADDR [NREG] = '{ADDR_FORCE_LEVEL_DAC,
    ADDR_UNIT_ENABLE, ADDR_CHANNEL_STATE, ADDR_UNIT_STATE,
    ADDR_MEASURE_ENABLE, ADDR_DIFF_COMP_ENABLE, ADDR_OVD_MASK_CH0,
    ADDR_OVD_MASK_CH1};
  localparam logic [15:0] REG_RST [NREG] = '{RST_FORCE_LEVEL_DAC,
    RST_UNIT_ENABLE, RST_CHANNEL_STATE, RST_UNIT_STATE,
    RST_MEASURE_ENABLE, RST_DIFF_COMP_ENABLE, RST_OVD_MASK, RST_OVD_MASK};

  // serial sampling in the reference clock; sclk edges found by history
  logic sclk_d_r;
  logic cs_d_r;
  logic [FRAME_W-1:0] shift_r;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic rd_mode_r;
  logic [15:0] rd_shift_r;
  logic sdo_r;
  logic rise_w;
  logic fall_w;
  logic frame_end_w;
  logic frame_ok_w;
  logic is_read_w;
  logic addr_done_w;
  logic [4:0] addr_w;
  logic [4:0] rd_addr_w;
  logic [15:0] data_w;
  logic [15:0] q_w [NREG];
  logic [NREG-1:0] load_w;
  logic [NREG-1:0] rd_hit_w;
  logic [15:0] rd_data_w;
  logic [15:0] level_q_w;
  logic [15:0] enable_q_w;
  logic [15:0] chan_q_w;
  logic [15:0] state_q_w;
  logic [15:0] meas_q_w;
  logic [15:0] diff_q_w;
  logic [15:0] mask0_q_w;
  logic [15:0] mask1_q_w;
  logic [4:0] range_dec_w;

  assign rise_w = SCLK_I & ~sclk_d_r & ~CS_N_I;
  assign fall_w = ~SCLK_I & sclk_d_r & ~CS_N_I;
  assign frame_end_w = CS_N_I & ~cs_d_r;
  // short or long frames are dropped so a partial word never lands
  assign frame_ok_w = frame_end_w & (cnt_r == 5'(FRAME_W));
  assign is_read_w = shift_r[RD_BIT];
  assign addr_w = shift_r[DATA_W +: ADDR_W];
  assign data_w = shift_r[DATA_W-1:0];
  assign cnt_nxt = (cnt_r == 5'h1F) ? cnt_r : cnt_r + 5'h01;
  // the last address bit is still on the data pin at the sixth rise
  assign addr_done_w = rise_w & (cnt_r == 5'(ADDR_W));
  assign rd_addr_w = {shift_r[ADDR_W-2:0], SDI_I};

  genvar g;
  generate
    for (g = 0; g < NREG; g++)
    begin : g_reg
      assign load_w[g] = frame_ok_w & ~is_read_w &
        (addr_w == REG_ADDR[g]);
      assign rd_hit_w[g] = (rd_addr_w == REG_ADDR[g]);
      pmsc_reg16 #(.RST_VAL(REG_RST[g])) u_reg (
        .REF_CLK_I(REF_CLK_I),
        .RST_I(RST_I),
        .load_i(load_w[g]),
        .data_i(data_w),
        .q_o(q_w[g])
      );
    end
  endgenerate

  // unmapped reads return zero
  always_comb
  begin
    rd_data_w = 16'h0000;
    for (int i = 0; i < NREG; i++)
      if (rd_hit_w[i])
        rd_data_w = q_w[i];
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      sclk_d_r <= SCLK_I;
      cs_d_r <= CS_N_I;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      cnt_r <= 5'h00;
    else if (CS_N_I)
      cnt_r <= 5'h00;
    else if (rise_w)
      cnt_r <= cnt_nxt;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      shift_r <= '0;
    else if (rise_w)
      shift_r <= {shift_r[FRAME_W-2:0], SDI_I};
  end

  // the flag moves along the shifter, so it is kept apart once seen
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      rd_mode_r <= 1'b0;
    else if (CS_N_I)
      rd_mode_r <= 1'b0;
    else if (addr_done_w)
      rd_mode_r <= shift_r[ADDR_W-1];
  end

  // readback: once flag and address are in, data goes out on falling edges
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      rd_shift_r <= 16'h0000;
      sdo_r <= 1'b0;
    end
    else if (addr_done_w)
      rd_shift_r <= rd_data_w;
    else if (fall_w && rd_mode_r)
    begin
      sdo_r <= rd_shift_r[15];
      rd_shift_r <= {rd_shift_r[14:0], 1'b0};
    end
  end

  assign SDO_O = sdo_r;
  // driven before the first data bit so the host never samples a float
  assign SDO_OE_O = ~CS_N_I & rd_mode_r;

  // register taps
  assign level_q_w = q_w[0];
  assign enable_q_w = q_w[1];
  assign chan_q_w = q_w[2];
  assign state_q_w = q_w[3];
  assign meas_q_w = q_w[4];
  assign diff_q_w = q_w[5];
  assign mask0_q_w = q_w[6];
  assign mask1_q_w = q_w[7];

  // decoded controls; register ordering from the host limits spikes
  assign FORCE_LEVEL_DAC_O = level_q_w;
  assign PARAM_UNIT_ON_O = enable_q_w[EN_PARAM_UNIT_BIT];
  assign TERM_LEVEL_FORCE_O = enable_q_w[EN_TERM_LEVEL_BIT];
  assign PIN_ELECTRONICS_ON_O = ~enable_q_w[EN_PIN_ELEC_OFF_BIT];
  assign HIGH_VOLTAGE_OUTPUT_O = chan_q_w[CH_HV_OUT_BIT];
  assign ACTIVE_LOAD_O = chan_q_w[CH_LOAD_BIT];
  assign TERMINATION_DRIVE_O = chan_q_w[CH_TERM_DRIVE_BIT];
  assign INPUT_SELECT_O = state_q_w[ST_INSEL_HI:ST_INSEL_LO];
  assign EXT_SENSE_O = state_q_w[ST_EXT_SENSE_BIT];
  // clamps need a closed loop, so they stay off with the unit
  assign CLAMP_ON_O = state_q_w[ST_CLAMP_BIT] & PARAM_UNIT_ON_O;
  assign FORCE_CURRENT_O = state_q_w[ST_FORCE_I_BIT];
  assign MEASURE_CURRENT_O = state_q_w[ST_MEAS_I_BIT];
  // codes 0XX share the smallest range E, so a zero word lands there;
  // codes 1XX pick A..D from the low bits; all open when the unit is off
  assign range_dec_w = state_q_w[ST_RANGE_HI] ?
    (5'h01 << state_q_w[ST_RANGE_LO +: 2]) : 5'h10;
  assign RANGE_SWITCH_O = PARAM_UNIT_ON_O ? range_dec_w : 5'h00;
  assign SHARED_MEASURE_OE_O = meas_q_w[MEAS_EN_BIT];
  assign DIFF_COMPARE_O = diff_q_w[0];
  assign OVD_ALARM_MASK0_O = mask0_q_w;
  assign OVD_ALARM_MASK1_O = mask1_q_w;
endmodule : pmsc_ctrl
`default_nettype wire

// [dv/pmsc_host.sv]
// host model: serial frames to the unit control registers
`timescale 1ns/10ps
`default_nettype none
module pmsc_host (
  input wire logic clk_i,
  input wire logic sdo_i,
  input wire logic oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // sclk stands low between frames; phases of two clocks
  task xfer(input logic rd, input logic [4:0] a, input logic [15:0] d,
            output logic [15:0] q);
    logic [21:0] f;
    f = {rd, a, d};
    @(negedge clk_i) cs_n_o = 1'b0;
    for (int i = 21; i >= 0; i--)
    begin
      sdi_o = f[i];
      repeat (2) @(negedge clk_i);
      sclk_o = 1'b1;
      // a bit only counts while the device drives the line
      if (i < 16) q[i] = sdo_i & oe_i;
      repeat (2) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (2) @(negedge clk_i);
    cs_n_o = 1'b1;
    // deselected: data line no longer holds the last bit
    sdi_o = ~sdi_o;
    repeat (3) @(negedge clk_i);
  endtask : xfer
endmodule : pmsc_host
`default_nettype wire

// [dv/pmsc_ctrl_chk.sv]
// checker: relations between the unit control outputs
`timescale 1ns/10ps
`default_nettype none
module pmsc_ctrl_chk (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic CS_N_I,
  input wire logic SDO_OE_O,
  input wire logic [15:0] FORCE_LEVEL_DAC_O,
  input wire logic PARAM_UNIT_ON_O,
  input wire logic [4:0] RANGE_SWITCH_O,
  input wire logic FORCE_CURRENT_O,
  input wire logic CLAMP_ON_O,
  input wire logic PIN_ELECTRONICS_ON_O,
  input wire logic SHARED_MEASURE_OE_O,
  input wire logic DIFF_COMPARE_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  range_open_a: assert property (
    !PARAM_UNIT_ON_O |-> RANGE_SWITCH_O == 5'h00) else $error("range closed");
  range_one_a: assert property (
    PARAM_UNIT_ON_O |-> $onehot(RANGE_SWITCH_O)) else $error("range not one");
  clamp_unit_a: assert property (
    CLAMP_ON_O |-> PARAM_UNIT_ON_O) else $error("clamp while off");
  sdo_frame_a: assert property (
    SDO_OE_O |-> !CS_N_I && !$past(CS_N_I))
    else $error("sdo driven outside frame");
  level_hold_a: assert property (
    !CS_N_I && !$past(CS_N_I) |-> $stable(FORCE_LEVEL_DAC_O))
    else $error("level changed in frame");
  mode_land_a: assert property (
    $changed(FORCE_CURRENT_O) |-> $past(CS_N_I) && !$past(CS_N_I, 2))
    else $error("mode change off time");
  unit_land_a: assert property (
    $changed(PARAM_UNIT_ON_O) |-> $past(CS_N_I) && !$past(CS_N_I, 2))
    else $error("enable change off time");
  range_land_a: assert property (
    $changed(RANGE_SWITCH_O) |-> $past(CS_N_I) && !$past(CS_N_I, 2))
    else $error("range change off time");
  reset_out_a: assert property (
    $fell(RST_I) |-> PIN_ELECTRONICS_ON_O && !PARAM_UNIT_ON_O
    && !SHARED_MEASURE_OE_O && !DIFF_COMPARE_O) else $error("reset outputs");
endmodule : pmsc_ctrl_chk
bind pmsc_ctrl pmsc_ctrl_chk pmsc_ctrl_chk_i (.REF_CLK_I(REF_CLK_I),
  .RST_I(RST_I), .CS_N_I(CS_N_I), .SDO_OE_O(SDO_OE_O),
  .FORCE_LEVEL_DAC_O(FORCE_LEVEL_DAC_O), .PARAM_UNIT_ON_O(PARAM_UNIT_ON_O),
  .RANGE_SWITCH_O(RANGE_SWITCH_O), .FORCE_CURRENT_O(FORCE_CURRENT_O),
  .CLAMP_ON_O(CLAMP_ON_O), .PIN_ELECTRONICS_ON_O(PIN_ELECTRONICS_ON_O),
  .SHARED_MEASURE_OE_O(SHARED_MEASURE_OE_O), .DIFF_COMPARE_O(DIFF_COMPARE_O));
`default_nettype wire

// [dv/pmsc_ctrl_tb.sv]
// testbench: mode switching sequences of the parametric unit
`timescale 1ns/10ps
`default_nettype none
module pmsc_ctrl_tb;
  logic clk, rst, sclk, cs_n, sdi, sdo, oe, on, fi, pe;
  logic mi, ext, cl, tl, hv, ld, td, sm, dc;
  logic [15:0] dac, q, st, ax, m0, m1;
  logic [4:0] rng;
  logic [1:0] isel;
  int err_total, samples_checked;
  // status word: pin electronics, unit on, force current, input, range
  assign st = {6'h00, pe, on, fi, isel, rng};
  // side word: measure, sense, clamp, level, channel, shared out, compare
  assign ax = {7'h00, mi, ext, cl, tl, hv, ld, td, sm, dc};
  pmsc_host pmsc_host_i (.clk_i(clk), .sdo_i(sdo), .oe_i(oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .sdi_o(sdi));
  pmsc_ctrl pmsc_ctrl_i (.REF_CLK_I(clk), .RST_I(rst), .SCLK_I(sclk),
    .CS_N_I(cs_n), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(oe),
    .FORCE_LEVEL_DAC_O(dac), .PARAM_UNIT_ON_O(on), .RANGE_SWITCH_O(rng),
    .FORCE_CURRENT_O(fi), .MEASURE_CURRENT_O(mi), .INPUT_SELECT_O(isel),
    .EXT_SENSE_O(ext), .CLAMP_ON_O(cl), .TERM_LEVEL_FORCE_O(tl),
    .PIN_ELECTRONICS_ON_O(pe), .HIGH_VOLTAGE_OUTPUT_O(hv),
    .ACTIVE_LOAD_O(ld), .TERMINATION_DRIVE_O(td),
    .SHARED_MEASURE_OE_O(sm), .DIFF_COMPARE_O(dc),
    .OVD_ALARM_MASK0_O(m0), .OVD_ALARM_MASK1_O(m1));
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [15:0] d, input logic [15:0] e);
    pmsc_host_i.xfer(1'b0, a, d, q);
    chk("status", st, e);
  endtask : wr
  task rd(input logic [4:0] a, input logic [15:0] e);
    pmsc_host_i.xfer(1'b1, a, 16'h0000, q);
    chk("readback", q, e);
  endtask : rd
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // about 30 frames of under 100 clocks each
  initial
  begin
    #200000;
    err_total++;
    test_done;
  end
  initial
  begin
    rst = 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    @(negedge clk);
    chk("status", st, 16'h0200);
    chk("aux", ax, 16'h0000);
    for (int i = 11; i < 20; i++) rd(5'(i), 16'h0000);
    wr(5'h0E, 16'h0202, 16'h0240);
    wr(5'h0C, 16'h0004, 16'h0350);
    wr(5'h0E, 16'h0108, 16'h03B0);
    wr(5'h0B, 16'hA5C3, 16'h03B0);
    chk("level", dac, 16'hA5C3);
    wr(5'h0E, 16'h020C, 16'h03C1);
    wr(5'h0E, 16'h0006, 16'h0304);
    wr(5'h0B, 16'h1234, 16'h0304);
    wr(5'h0E, 16'h03D7, 16'h0368);
    chk("aux", ax, 16'h01C0);
    wr(5'h0E, 16'h0345, 16'h0362);
    wr(5'h13, 16'hFFFF, 16'h0362);
    rd(5'h0B, 16'h1234);
    rd(5'h0E, 16'h0345);
    wr(5'h0D, 16'h0007, 16'h0362);
    wr(5'h0F, 16'h0001, 16'h0362);
    wr(5'h10, 16'h0001, 16'h0362);
    wr(5'h11, 16'hBEEF, 16'h0362);
    wr(5'h12, 16'h1357, 16'h0362);
    chk("aux", ax, 16'h005F);
    chk("mask0", m0, 16'hBEEF);
    chk("mask1", m1, 16'h1357);
    rd(5'h12, 16'h1357);
    wr(5'h0C, 16'h0003, 16'h0060);
    chk("aux", ax, 16'h003F);
    wr(5'h0C, 16'h0000, 16'h0260);
    rd(5'h0C, 16'h0000);
    test_done;
  end
endmodule : pmsc_ctrl_tb
`default_nettype wire
